//--- logic/parallel_slave_host_port.sv
// parallel slave host port: async 8-bit host latch with status and irq
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - enable bit 4 set turns the data pins into an 8-bit slave bus
// - host strobes arrive with no shared clock and are sampled through a two-flop synchroniser on clk_in
// - enable reassigns three control pins as read, write and select inputs
// - all three control pin direction bits must be inputs for port use
// - host write spans select and write low, ends when either goes high
// - write end sets the irq flag and in-buffer-full
// - select and read low drive the out latch onto pins, set out-full
// - cpu write during host read shows at once but leaves out-full alone
// - read end releases the pins and sets the irq flag
// - software waits for the irq flag then polls the full bits
// - in-buffer-full is read-only bit 7, resets to zero
// - out-buffer-full is read-only bit 6, clears once host takes the byte
// - overrun bit 5 sets on write while byte unread, software clears it
// - enable bit 4 is read/write, resets to zero
// - control bits 3 to 0 read zero and ignore writes
// - port works only in internal-program microcontroller mode
// - irq flag has matching enable and priority bits
module parallel_slave_host_port #(
   parameter int DATA_W = 8
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   // register port
   input wire logic [2:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [7:0] reg_rdata_out,
   // mode from the system: high in internal-program microcontroller mode
   input wire logic mcu_mode_in,
   // host pins
   input wire logic read_strobe_pin_n_in,
   input wire logic write_strobe_pin_n_in,
   input wire logic select_pin_n_in,
   input wire logic [DATA_W-1:0] slave_data_pins_in,
   output logic [DATA_W-1:0] slave_data_pins_out,
   output logic slave_data_pins_oe_out,
   // interrupt
   output logic irq_out,
   output logic irq_high_priority_out
);

   // ==========================================
   // register state
   logic enable_q;
   logic in_full_q;
   logic out_full_q;
   logic overrun_q;
   logic [2:0] direction_q;
   logic irq_flag_q;
   logic irq_enable_q;
   logic irq_priority_q;
   logic [DATA_W-1:0] out_latch_q;
   logic [DATA_W-1:0] in_latch_q;
   logic [DATA_W-1:0] capture_q;
   logic [7:0] rdata_q;

   // ==========================================
   // synchronisers
   host_port_pkg::strobes_s strobe_meta_q;
   host_port_pkg::strobes_s strobe_sync_q;
   logic [DATA_W-1:0] data_meta_q;
   logic [DATA_W-1:0] data_sync_q;
   host_port_pkg::cycle_e cycle_q;
   host_port_pkg::cycle_e cycle_d;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         strobe_meta_q <= '1;
         strobe_sync_q <= '1;
      end else begin
         strobe_meta_q <= {select_pin_n_in, read_strobe_pin_n_in,
                           write_strobe_pin_n_in};
         strobe_sync_q <= strobe_meta_q;
      end
   end

   // the data bus shares the strobe delay, so the host must hold it steady
   // until the strobe rises; a bus changing mid-strobe may be caught torn
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         data_meta_q <= '0;
         data_sync_q <= '0;
      end else begin
         data_meta_q <= slave_data_pins_in;
         data_sync_q <= data_meta_q;
      end
   end

   // ==========================================
   // decode helpers
   function automatic logic hit(input logic [2:0] addr,
                                input logic [2:0] offset,
                                input logic strobe);
      hit = strobe && (addr == offset);
   endfunction : hit

   logic port_on;
   logic write_req;
   logic read_req;
   logic write_end;
   logic read_start;
   logic read_end;
   logic cpu_data_write;
   logic cpu_data_read;
   logic cpu_ctrl_write;
   logic cpu_flag_write;

   // mcu mode only
   // a control pin left as an output would fight the host, so stay off
   assign port_on = enable_q && mcu_mode_in &&
                    (direction_q == host_port_pkg::DIRECTION_ALL_IN);

   assign write_req = port_on && !strobe_sync_q.select_n &&
                      !strobe_sync_q.write_n;
   assign read_req = port_on && !strobe_sync_q.select_n &&
                     !strobe_sync_q.read_n;

   assign cpu_data_write = hit(reg_addr_in, host_port_pkg::DATA_OFFSET,
                               reg_write_in);
   assign cpu_data_read = hit(reg_addr_in, host_port_pkg::DATA_OFFSET,
                              reg_read_in);
   assign cpu_ctrl_write = hit(reg_addr_in, host_port_pkg::CONTROL_OFFSET,
                               reg_write_in);
   assign cpu_flag_write = hit(reg_addr_in, host_port_pkg::FLAG_OFFSET,
                               reg_write_in);

   // ==========================================
   // host cycle tracker
   // a write takes priority if a host asserts both strobes at once
   always_comb begin
      cycle_d = cycle_q;
      case (cycle_q)
         host_port_pkg::IDLE: begin
            if (write_req) begin
               cycle_d = host_port_pkg::HOST_WRITE;
            end else if (read_req) begin
               cycle_d = host_port_pkg::HOST_READ;
            end
         end
         host_port_pkg::HOST_WRITE: begin
            if (!write_req) begin
               cycle_d = host_port_pkg::IDLE;
            end
         end
         host_port_pkg::HOST_READ: begin
            if (!read_req) begin
               cycle_d = host_port_pkg::IDLE;
            end
         end
         default: begin
            cycle_d = host_port_pkg::IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cycle_q <= host_port_pkg::IDLE;
      end else begin
         cycle_q <= cycle_d;
      end
   end

   assign write_end = (cycle_q == host_port_pkg::HOST_WRITE) && !write_req;
   assign read_start = (cycle_q != host_port_pkg::HOST_READ) &&
                       (cycle_d == host_port_pkg::HOST_READ);
   assign read_end = (cycle_q == host_port_pkg::HOST_READ) && !read_req;

   // ==========================================
   // host data path
   // capture follows the bus while the write is held, so the last
   // synchronised byte before the strobe rises is the one kept
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         capture_q <= '0;
      end else if (write_req) begin
         capture_q <= data_sync_q;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         in_latch_q <= '0;
      end else if (write_end) begin
         in_latch_q <= capture_q;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         out_latch_q <= '0;
      end else if (cpu_data_write) begin
         out_latch_q <= reg_wdata_in[DATA_W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         slave_data_pins_oe_out <= 1'b0;
      end else begin
         slave_data_pins_oe_out <= (cycle_d == host_port_pkg::HOST_READ);
      end
   end

   // pins always show the latch; the enable alone decides who drives them
   assign slave_data_pins_out = out_latch_q;

   // ==========================================
   // control and status bits
   // enable read/write
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         enable_q <= host_port_pkg::CONTROL_RESET[host_port_pkg::ENABLE_BIT];
      end else if (cpu_ctrl_write) begin
         enable_q <= reg_wdata_in[host_port_pkg::ENABLE_BIT];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         in_full_q <= host_port_pkg::CONTROL_RESET[host_port_pkg::IN_FULL_BIT];
      end else if (write_end) begin
         in_full_q <= 1'b1;
      end else if (cpu_data_read) begin
         in_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         out_full_q <=
            host_port_pkg::CONTROL_RESET[host_port_pkg::OUT_FULL_BIT];
      end else if (read_start) begin
         out_full_q <= 1'b1;
      end else if (cpu_data_write &&
                   cycle_q != host_port_pkg::HOST_READ) begin
         out_full_q <= 1'b1;
      end else if (read_end) begin
         out_full_q <= 1'b0;
      end
   end

   // overrun sticky
   // a write of zero clears it; a set in the same cycle wins
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         overrun_q <= host_port_pkg::CONTROL_RESET[host_port_pkg::OVERRUN_BIT];
      end else if (write_end && in_full_q) begin
         overrun_q <= 1'b1;
      end else if (cpu_ctrl_write &&
                   !reg_wdata_in[host_port_pkg::OVERRUN_BIT]) begin
         overrun_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         direction_q <= host_port_pkg::DIRECTION_RESET;
      end else if (hit(reg_addr_in, host_port_pkg::DIRECTION_OFFSET,
                       reg_write_in)) begin
         direction_q <= reg_wdata_in[2:0];
      end
   end

   // ==========================================
   // interrupt flag, enable, priority
   // flag on write end or read end
   // held until cleared
   // write one clears; an event in the same cycle wins over the clear
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_flag_q <= 1'b0;
      end else if (write_end || read_end) begin
         irq_flag_q <= 1'b1;
      end else if (cpu_flag_write &&
                   reg_wdata_in[host_port_pkg::IRQ_FLAG_BIT]) begin
         irq_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_enable_q <= 1'b0;
      end else if (hit(reg_addr_in, host_port_pkg::ENABLE_OFFSET,
                       reg_write_in)) begin
         irq_enable_q <= reg_wdata_in[host_port_pkg::IRQ_FLAG_BIT];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_priority_q <= 1'b0;
      end else if (hit(reg_addr_in, host_port_pkg::PRIORITY_OFFSET,
                       reg_write_in)) begin
         irq_priority_q <= reg_wdata_in[host_port_pkg::IRQ_FLAG_BIT];
      end
   end

   assign irq_out = irq_flag_q && irq_enable_q;
   assign irq_high_priority_out = irq_flag_q && irq_enable_q &&
                                  irq_priority_q;

   // ==========================================
   // register read port
   host_port_pkg::status_s status;
   assign status = '{in_buffer_full: in_full_q,
                     out_buffer_full: out_full_q,
                     in_buffer_overrun: overrun_q,
                     host_port_enable: enable_q};

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_q <= host_port_pkg::UNMAPPED_READ;
      end else if (reg_read_in) begin
         case (reg_addr_in)
            host_port_pkg::CONTROL_OFFSET: begin
               rdata_q <= {status, 4'h0};
            end
            host_port_pkg::DATA_OFFSET: begin
               rdata_q <= 8'(in_latch_q);
            end
            host_port_pkg::DIRECTION_OFFSET: begin
               rdata_q <= {5'h00, direction_q};
            end
            host_port_pkg::FLAG_OFFSET: begin
               rdata_q <= {irq_flag_q, 7'h00};
            end
            host_port_pkg::ENABLE_OFFSET: begin
               rdata_q <= {irq_enable_q, 7'h00};
            end
            host_port_pkg::PRIORITY_OFFSET: begin
               rdata_q <= {irq_priority_q, 7'h00};
            end
            default: begin
               rdata_q <= host_port_pkg::UNMAPPED_READ;
            end
         endcase
      end else begin
         rdata_q <= host_port_pkg::UNMAPPED_READ;
      end
   end

   assign reg_rdata_out = rdata_q;

endmodule : parallel_slave_host_port

//--- shared/host_port_pkg.sv
// shared constants and types for the parallel slave host port
package host_port_pkg;

   // ==========================================
   // register map (byte offsets, 8-bit data)
   localparam logic [2:0] CONTROL_OFFSET = 3'h0;
   localparam logic [2:0] DATA_OFFSET = 3'h1;
   localparam logic [2:0] DIRECTION_OFFSET = 3'h2;
   localparam logic [2:0] FLAG_OFFSET = 3'h3;
   localparam logic [2:0] ENABLE_OFFSET = 3'h4;
   localparam logic [2:0] PRIORITY_OFFSET = 3'h5;

   // ==========================================
   // field positions
   localparam int IN_FULL_BIT = 7;
   localparam int OUT_FULL_BIT = 6;
   localparam int OVERRUN_BIT = 5;
   localparam int ENABLE_BIT = 4;
   localparam int IRQ_FLAG_BIT = 7;

   // ==========================================
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [2:0] DIRECTION_RESET = 3'h7;
   localparam logic [2:0] DIRECTION_ALL_IN = 3'h7;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ==========================================
   // carriers
   typedef struct packed {
      logic select_n;
      logic read_n;
      logic write_n;
   } strobes_s;

   typedef struct packed {
      logic in_buffer_full;
      logic out_buffer_full;
      logic in_buffer_overrun;
      logic host_port_enable;
   } status_s;

   typedef enum logic [1:0] {
      IDLE = 2'b00,
      HOST_WRITE = 2'b01,
      HOST_READ = 2'b10
   } cycle_e;

endpackage : host_port_pkg

//--- verif/host_cpu_model.sv
// external microprocessor model driving the host pins
`timescale 1ns/1ps
module host_cpu_model #(
   parameter int HOLD = 5
) (
   input wire logic clk_in,
   input wire logic [7:0] dev_data_in,
   input wire logic dev_oe_in,
   output logic select_n_out,
   output logic read_n_out,
   output logic write_n_out,
   output logic [7:0] bus_out
);
   logic [7:0] drv_q = 8'h00;
   logic drv_oe_q = 1'b0;
   logic [7:0] float_q = 8'h5a;
   initial begin
      select_n_out = 1'b1;
      read_n_out = 1'b1;
      write_n_out = 1'b1;
   end
   // undriven bus toggles so a stale byte never passes
   always @(posedge clk_in) float_q <= ~float_q;
   assign bus_out = dev_oe_in ? dev_data_in : drv_oe_q ? drv_q : float_q;

   // levels only, select and strobe held low throughout
   task automatic host_write(input logic [7:0] d);
      @(posedge clk_in);
      drv_q <= d;
      drv_oe_q <= 1'b1;
      select_n_out <= 1'b0;
      write_n_out <= 1'b0;
      repeat (HOLD) @(posedge clk_in);
      select_n_out <= 1'b1;
      write_n_out <= 1'b1;
      @(posedge clk_in);
      drv_oe_q <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask : host_write
   task automatic begin_read;
      @(posedge clk_in);
      select_n_out <= 1'b0;
      read_n_out <= 1'b0;
      repeat (HOLD) @(posedge clk_in);
   endtask : begin_read
   task automatic end_read(output logic [7:0] d);
      @(posedge clk_in);
      d = bus_out;
      select_n_out <= 1'b1;
      read_n_out <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask : end_read
endmodule : host_cpu_model

//--- verif/parallel_slave_host_port_chk.sv
// checker for the parallel slave host port
`timescale 1ns/1ps
module parallel_slave_host_port_chk #(
   parameter int DATA_W = 8
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [2:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic mcu_mode_in,
   input wire logic read_strobe_pin_n_in,
   input wire logic write_strobe_pin_n_in,
   input wire logic select_pin_n_in,
   input wire logic [DATA_W-1:0] slave_data_pins_in,
   input wire logic [DATA_W-1:0] slave_data_pins_out,
   input wire logic slave_data_pins_oe_out,
   input wire logic irq_out,
   input wire logic irq_high_priority_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   // ==========================================
   // register port
   property p_rdata_idle;
      !$past(reg_read_in) |-> reg_rdata_out == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read");
   property p_ctrl_low;
      $past(reg_read_in) &&
         $past(reg_addr_in) == host_port_pkg::CONTROL_OFFSET
         |-> reg_rdata_out[3:0] == 4'h0;
   endproperty
   a_ctrl_low: assert property (p_ctrl_low)
      else $error("control low bits not zero");
   property p_unmapped;
      $past(reg_read_in) &&
         $past(reg_addr_in) > host_port_pkg::PRIORITY_OFFSET
         |-> reg_rdata_out == host_port_pkg::UNMAPPED_READ;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_out_latch;
      $past(reg_write_in) &&
         $past(reg_addr_in) == host_port_pkg::DATA_OFFSET
         |-> slave_data_pins_out == $past(reg_wdata_in);
   endproperty
   a_out_latch: assert property (p_out_latch)
      else $error("out latch not updated by data write");

   // ==========================================
   // host pins: three-edge lag through the synchronisers
   property p_oe_cause;
      slave_data_pins_oe_out
         |-> !$past(select_pin_n_in, 3) && !$past(read_strobe_pin_n_in, 3);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("pins driven without host read");
   property p_oe_end;
      $fell(slave_data_pins_oe_out)
         |-> $past(select_pin_n_in, 3) || $past(read_strobe_pin_n_in, 3);
   endproperty
   a_oe_end: assert property (p_oe_end)
      else $error("pins released while read held");
   property p_mode;
      !mcu_mode_in [*2] |-> !slave_data_pins_oe_out;
   endproperty
   a_mode: assert property (p_mode)
      else $error("pins driven outside controller mode");
   property p_prio;
      irq_high_priority_out |-> irq_out;
   endproperty
   a_prio: assert property (p_prio)
      else $error("priority irq without irq");
endmodule : parallel_slave_host_port_chk

bind parallel_slave_host_port parallel_slave_host_port_chk #(
   .DATA_W(DATA_W)
) i_chk (
   .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
   .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
   .mcu_mode_in(mcu_mode_in), .read_strobe_pin_n_in(read_strobe_pin_n_in),
   .write_strobe_pin_n_in(write_strobe_pin_n_in),
   .select_pin_n_in(select_pin_n_in),
   .slave_data_pins_in(slave_data_pins_in),
   .slave_data_pins_out(slave_data_pins_out),
   .slave_data_pins_oe_out(slave_data_pins_oe_out),
   .irq_out(irq_out), .irq_high_priority_out(irq_high_priority_out));

//--- verif/tb_parallel_slave_host_port.sv
// self-checking bench for the parallel slave host port
`timescale 1ns/1ps
module tb_parallel_slave_host_port;
   typedef struct packed {
      logic [2:0] a;
      logic [7:0] w;
      logic [7:0] e;
   } row_s;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic mode = 1'b1;
   logic [7:0] rdata, pins, bus, got;
   logic oe, irq, irq_hi, sel_n, rd_n, wr_n;
   int n_mismatch = 0;
   int comparisons = 0;
   // write a value, then expect this read back
   row_s rows [8] = '{
      '{3'h2, 8'h05, 8'h05}, '{3'h2, 8'hff, 8'h07},
      '{3'h0, 8'hff, 8'h10}, '{3'h4, 8'hff, 8'h80},
      '{3'h5, 8'hff, 8'h80}, '{3'h6, 8'hff, 8'h00},
      '{3'h7, 8'h5a, 8'h00}, '{3'h1, 8'ha5, 8'h00}};

   parallel_slave_host_port i_parallel_slave_host_port (
      .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en),
      .reg_rdata_out(rdata), .mcu_mode_in(mode),
      .read_strobe_pin_n_in(rd_n), .write_strobe_pin_n_in(wr_n),
      .select_pin_n_in(sel_n), .slave_data_pins_in(bus),
      .slave_data_pins_out(pins), .slave_data_pins_oe_out(oe),
      .irq_out(irq), .irq_high_priority_out(irq_hi));
   host_cpu_model i_host_cpu_model (
      .clk_in(clk_in), .dev_data_in(pins), .dev_oe_in(oe),
      .select_n_out(sel_n), .read_n_out(rd_n), .write_n_out(wr_n),
      .bus_out(bus));

   initial forever #2 clk_in = ~clk_in;

   task automatic check(input string n, input logic [7:0] s, e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_in);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e, string n);
      @(posedge clk_in);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_in);
      rd_en <= 1'b0;
      @(negedge clk_in);
      check(n, rdata, e);
   endtask : rd
   task automatic chk_irq(input logic e);
      @(negedge clk_in);
      check("irq", {7'h00, irq}, {7'h00, e});
   endtask : chk_irq
   task automatic reset_dut;
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
   endtask : reset_dut
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_in);
      n_mismatch++;
      stop_test();
   end

   initial begin
      reset_dut();
      rd(3'h0, 8'h00, "ctrl reset");
      rd(3'h2, 8'h07, "dir reset");
      for (int i = 0; i < 8; i++) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e, "row");
      end
      check("pins", pins, 8'ha5);
      rd(3'h0, 8'h50, "obf cpu");
      $display("register test done");
      i_host_cpu_model.begin_read();
      i_host_cpu_model.end_read(got);
      check("host read", got, 8'ha5);
      rd(3'h0, 8'h10, "obf taken");
      rd(3'h3, 8'h80, "flag read");
      check("irq hi", {7'h00, irq_hi}, 8'h01);
      wr(3'h3, 8'h80);
      chk_irq(1'b0);
      $display("host read test done");
      i_host_cpu_model.host_write(8'h3c);
      rd(3'h0, 8'h90, "ibf set");
      i_host_cpu_model.host_write(8'hc3);
      rd(3'h0, 8'hb0, "overrun");
      rd(3'h1, 8'hc3, "in latch");
      rd(3'h0, 8'h30, "ibf clear");
      wr(3'h0, 8'h10);
      rd(3'h0, 8'h10, "ovr clear");
      wr(3'h3, 8'h80);
      $display("host write test done");
      // cpu write mid read, with the irq masked
      wr(3'h4, 8'h00);
      i_host_cpu_model.begin_read();
      rd(3'h0, 8'h50, "obf read start");
      check("oe on", {7'h00, oe}, 8'h01);
      wr(3'h1, 8'h77);
      i_host_cpu_model.end_read(got);
      check("late data", got, 8'h77);
      rd(3'h3, 8'h80, "flag masked");
      check("oe off", {7'h00, oe}, 8'h00);
      chk_irq(1'b0);
      wr(3'h4, 8'h80);
      chk_irq(1'b1);
      wr(3'h5, 8'h00);
      @(negedge clk_in);
      check("irq lo", {7'h00, irq_hi}, 8'h00);
      wr(3'h3, 8'h80);
      chk_irq(1'b0);
      $display("mask test done");
      // port inactive: wrong mode, then a pin set as output
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_in);
         mode <= (k == 1);
         if (k == 1) wr(3'h2, 8'h03);
         i_host_cpu_model.host_write(8'h11);
         rd(3'h0, 8'h10, "inactive");
         rd(3'h3, 8'h00, "no flag");
      end
      wr(3'h2, 8'h07);
      $display("inactive test done");
      reset_dut();
      rd(3'h0, 8'h00, "ctrl rereset");
      rd(3'h2, 8'h07, "dir rereset");
      rd(3'h4, 8'h00, "mask rereset");
      $display("reset test done");
      stop_test();
   end
endmodule : tb_parallel_slave_host_port
